// >>> logic/sspc_regs.sv
// Sink status and PHY configuration register bank on AXI4-Lite.
// Assumes overflow and vsync inputs are synchronous to mclk.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sspc_defs.svh"

// Register map, one aligned 32-bit word each:
//   0x110 overflow status, read-to-clear
//         [3:0]   pixel FIFO overflow, streams one to four
//         [7:4]   video unpack FIFO overflow, streams one to four
//         [11:8]  video timing FIFO overflow, streams one to four
//         [31:12] zero
//   0x114 vsync state, read only
//         [3:0]   live vsync per stream, one cycle behind the pins
//         [31:4]  zero
//   0x200 PHY configuration, read/write
//         [0]     transceiver PLL reset, set out of reset
//         [1]     transceiver receive reset, set out of reset
//         [7:2]   zero, writes ignored
//         [8]     analog front reset
//         [9]     coding sublayer reset
//         [10]    elastic buffer reset
//         [11]    equalizer reset
//         [12]    common lane polarity invert
//         [15:13] loopback select
//         [31:16] zero, writes ignored
//   0x300 interrupt status, bit 0 set by any overflow event, write one
//         to clear; a new event in the clearing cycle keeps it set
//   0x304 interrupt mask, bit 0, clear out of reset
//
// Bus behaviour:
//   Write address and write data may arrive together or apart.
//   The response rises at the edge that takes the second of the two.
//   Read data rises at the edge that takes the address.
//   Readies stay low while a response waits for its handshake.
//   Unmapped addresses answer with a slave error and change nothing.
//   Writes to the two status words answer okay and change nothing.
//
// Hazards and limits:
//   Status inputs are taken as synchronous; no synchroniser is built in.
//   A read of the overflow word clears all twelve flags at once, so
//   software that polls must act on every bit it sees in one read.
//   The PHY outputs lag the register by one cycle, which keeps every
//   output straight from a flop at the cost of that cycle.
//   The PHY comes out of reset held in reset; software must clear the
//   two low bits before the receiver can run.
//   Byte strobes are honoured, so a byte write to the upper half only
//   leaves the PLL and receive resets as they were.
//   The overflow layout assumes four streams; other counts need the
//   field positions in the header moved to match.

// Function
// - Bits 0..3 flag pixel FIFO overflow per stream, cleared by reading.
// - Bits 4..7 flag video unpack FIFO overflow per stream.
// - Bits 8..11 flag video timing FIFO overflow per stream.
// - Vsync state register bits 0..3 show live vsync per stream.
// - Phy_configuration bits 1:0 drive transceiver PLL and receive resets.
// - Phy_configuration bits 1:0 come out of reset as 0x3.
// - Bits 8..11 drive analog, coding, buffer and equalizer resets.
// - Bit 12 drives common lane polarity, default zero.
// - Bits 15:13 drive loopback select, default zero.
module sspc_regs #(
    parameter int STREAMS = 4
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire sspc_pkg::sspc_word_t s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output sspc_pkg::sspc_resp_t      s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output sspc_pkg::sspc_word_t      s_axi_rdata,
    output sspc_pkg::sspc_resp_t      s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [STREAMS-1:0]   pix_fifo_overflow,
    input  wire logic [STREAMS-1:0]   unpack_fifo_overflow,
    input  wire logic [STREAMS-1:0]   timing_fifo_overflow,
    input  wire logic [STREAMS-1:0]   stream_vsync,
    output logic                      transceiver_pll_reset,
    output logic                      transceiver_rx_reset,
    output logic                      phy_analog_front_reset,
    output logic                      phy_coding_sublayer_reset,
    output logic                      phy_elastic_buffer_reset,
    output logic                      phy_equalizer_reset,
    output logic                      lane_polarity_invert,
    output sspc_pkg::sspc_lpb_t       phy_loopback_select,
    output logic                      irq
);
    import sspc_pkg::*;

    // State
    sspc_wstate_t      wstate_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [11:0]       awaddr_q;
    sspc_word_t        wdata_q;
    logic [3:0]        wstrb_q;
    logic [11:0]       ovf_q;
    logic [11:0]       ovf_d;
    logic [STREAMS-1:0] vsync_q;
    logic [15:0]       phy_q;
    logic              irq_sts_q;
    logic              irq_mask_q;

    // Channel handshakes
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire have_aw = aw_got_q || aw_fire;
    wire have_w  = w_got_q || w_fire;
    wire wr_go   = (wstate_q == SSPC_W_IDLE) && have_aw && have_w;
    wire [11:0]      wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
    wire sspc_word_t wr_data = w_got_q ? wdata_q : s_axi_wdata;
    wire [3:0]       wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;

    // Byte-lane write mask
    wire sspc_word_t strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                                  {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // Write address decode
    wire wr_phy  = wr_go && (wr_addr == `SSPC_OFF_PHY_CONFIGURATION);
    wire wr_ists = wr_go && (wr_addr == `SSPC_OFF_IRQ_STATUS);
    wire wr_imsk = wr_go && (wr_addr == `SSPC_OFF_IRQ_MASK);
    wire wr_hit  = wr_phy || wr_ists || wr_imsk
                   || (wr_addr == `SSPC_OFF_OVF_STATUS)
                   || (wr_addr == `SSPC_OFF_VSYNC_STATE);

    // Read address decode
    wire rd_ovf   = (s_axi_araddr == `SSPC_OFF_OVF_STATUS);
    wire rd_vs    = (s_axi_araddr == `SSPC_OFF_VSYNC_STATE);
    wire rd_phy   = (s_axi_araddr == `SSPC_OFF_PHY_CONFIGURATION);
    wire rd_ists  = (s_axi_araddr == `SSPC_OFF_IRQ_STATUS);
    wire rd_imsk  = (s_axi_araddr == `SSPC_OFF_IRQ_MASK);
    wire rd_hit   = rd_ovf || rd_vs || rd_phy || rd_ists || rd_imsk;
    wire ovf_read = ar_fire && rd_ovf;

    // Read data selection, unused bits zero
    wire sspc_word_t rd_word =
        rd_ovf  ? {20'h0_0000, ovf_q} :
        rd_vs   ? {{(32-STREAMS){1'b0}}, vsync_q} :
        rd_phy  ? {16'h0000, phy_q} :
        rd_ists ? {31'h0000_0000, irq_sts_q} :
        rd_imsk ? {31'h0000_0000, irq_mask_q} : 32'h0000_0000;

    // New overflow events grouped in register order
    wire [11:0] ovf_evt = {timing_fifo_overflow, unpack_fifo_overflow,
                           pix_fifo_overflow};
    wire        any_evt = |ovf_evt;

    // Sticky overflow flags: read clears, a same-cycle event survives
    always_comb begin
        ovf_d = ovf_q;
        if (ovf_read) begin
            ovf_d = 12'h000;
        end
        ovf_d = ovf_d | ovf_evt;
    end

    // Per-flag capture for all three FIFO groups of every stream
    for (genvar i = 0; i < 12; i++) begin : g_ovf
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                ovf_q[i] <= 1'b0;
            end else begin
                ovf_q[i] <= ovf_d[i];
            end
        end
    end

    // Live vsync sampling
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vsync_q <= '0;
        end else begin
            vsync_q <= stream_vsync;
        end
    end

    // PHY configuration register, power-up holds PHY in reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phy_q <= `SSPC_PHY_RESET;
        end else if (wr_phy) begin
            phy_q <= (phy_q & ~(strb_mask[15:0] & `SSPC_PHY_WR_MASK))
                   | (wr_data[15:0] & strb_mask[15:0]
                      & `SSPC_PHY_WR_MASK);
        end
    end

    // PHY control outputs from flops.
    // Reset values match the register reset, so the PHY sees its own
    // resets held from the first instant, before any edge arrives.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            transceiver_pll_reset     <= 1'b1;
            transceiver_rx_reset      <= 1'b1;
            phy_analog_front_reset    <= 1'b0;
            phy_coding_sublayer_reset <= 1'b0;
            phy_elastic_buffer_reset  <= 1'b0;
            phy_equalizer_reset       <= 1'b0;
            lane_polarity_invert      <= 1'b0;
            phy_loopback_select       <= 3'h0;
        end else begin
            transceiver_pll_reset     <= phy_q[`SSPC_PHY_PLL_RST_BIT];
            transceiver_rx_reset      <= phy_q[`SSPC_PHY_RX_RST_BIT];
            phy_analog_front_reset    <= phy_q[`SSPC_PHY_PMA_BIT];
            phy_coding_sublayer_reset <= phy_q[`SSPC_PHY_PCS_BIT];
            phy_elastic_buffer_reset  <= phy_q[`SSPC_PHY_BUF_BIT];
            phy_equalizer_reset       <= phy_q[`SSPC_PHY_EQ_BIT];
            lane_polarity_invert      <= phy_q[`SSPC_PHY_POL_BIT];
            phy_loopback_select       <=
                phy_q[`SSPC_PHY_LPB_MSB:`SSPC_PHY_LPB_LSB];
        end
    end

    // Interrupt status (set wins over write-one clear) and mask
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_sts_q  <= 1'b0;
            irq_mask_q <= 1'b0;
            irq        <= 1'b0;
        end else begin
            irq_sts_q <= any_evt || (irq_sts_q && !(wr_ists
                         && wr_strb[0] && wr_data[`SSPC_IRQ_OVF_BIT]));
            if (wr_imsk && wr_strb[0]) begin
                irq_mask_q <= wr_data[`SSPC_IRQ_OVF_BIT];
            end
            irq <= irq_sts_q && irq_mask_q;
        end
    end

    // Write channel capture and response.
    // The address and data halves are latched as they arrive, so a
    // master that offers them apart is served as well as one that
    // offers them together. Once both are held the write is applied
    // in that same cycle and the response is raised; both readies
    // then stay low until the response has been taken, which keeps
    // at most one write in flight and the latches free of overrun.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wstate_q      <= SSPC_W_IDLE;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SSPC_RESP_OKAY;
        end else begin
            case (wstate_q)
                SSPC_W_IDLE: begin
                    if (aw_fire) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= s_axi_awaddr;
                    end
                    if (w_fire) begin
                        w_got_q <= 1'b1;
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                    end
                    s_axi_awready <= !have_aw;
                    s_axi_wready  <= !have_w;
                    if (wr_go) begin
                        wstate_q      <= SSPC_W_RESP;
                        aw_got_q      <= 1'b0;
                        w_got_q       <= 1'b0;
                        s_axi_awready <= 1'b0;
                        s_axi_wready  <= 1'b0;
                        s_axi_bvalid  <= 1'b1;
                        s_axi_bresp   <= wr_hit ? `SSPC_RESP_OKAY
                                                : `SSPC_RESP_SLVERR;
                    end
                end
                SSPC_W_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid  <= 1'b0;
                        wstate_q      <= SSPC_W_IDLE;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                    end
                end
                default: wstate_q <= SSPC_W_IDLE;
            endcase
        end
    end

    // Read channel: one read at a time.
    // Data are captured at the address edge, so the read-to-clear of
    // the overflow word and the returned value refer to one cycle.
    // The address ready stays low until the data have been taken.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SSPC_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `SSPC_RESP_OKAY : `SSPC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule // sspc_regs

// >>> logic/sspc_defs.svh
// Register offsets, field positions and reset values of the sink status
// and PHY configuration bank. Included by the bank only; the bench uses literal values.
`ifndef SSPC_DEFS_SVH
`define SSPC_DEFS_SVH

`define SSPC_ADDR_W          12
`define SSPC_OFF_OVF_STATUS  12'h110
`define SSPC_OFF_VSYNC_STATE 12'h114
`define SSPC_OFF_PHY_CONFIGURATION  12'h200
`define SSPC_OFF_IRQ_STATUS  12'h300
`define SSPC_OFF_IRQ_MASK    12'h304

`define SSPC_OVF_PIX_LSB     0
`define SSPC_OVF_UNP_LSB     4
`define SSPC_OVF_TIM_LSB     8

`define SSPC_PHY_PLL_RST_BIT 0
`define SSPC_PHY_RX_RST_BIT  1
`define SSPC_PHY_PMA_BIT     8
`define SSPC_PHY_PCS_BIT     9
`define SSPC_PHY_BUF_BIT     10
`define SSPC_PHY_EQ_BIT      11
`define SSPC_PHY_POL_BIT     12
`define SSPC_PHY_LPB_LSB     13
`define SSPC_PHY_LPB_MSB     15
`define SSPC_PHY_RESET       16'h0003
`define SSPC_PHY_WR_MASK     16'hFF03

`define SSPC_IRQ_OVF_BIT     0
`define SSPC_IRQ_MASK_RESET  32'h0000_0000

`define SSPC_RESP_OKAY       2'h0
`define SSPC_RESP_SLVERR     2'h2

`endif

// >>> logic/sspc_pkg.sv
// Types shared by the status and PHY configuration bank and its bench.
package sspc_pkg;
    typedef logic [31:0] sspc_word_t;
    typedef logic [1:0]  sspc_resp_t;
    typedef logic [2:0]  sspc_lpb_t;
    typedef enum logic [0:0] {SSPC_W_IDLE, SSPC_W_RESP} sspc_wstate_t;
endpackage

// >>> tb/sspc_regs_checker.sv
// Port assertions of the status and PHY configuration bank.
// Bound to sspc_regs by the bench; full-word PHY writes, status reads and reset drive the checks.
`timescale 1ns/1ps
module sspc_regs_checker #(
    parameter int STREAMS = 4
) (
    input wire logic mclk, rst, s_axi_awvalid, s_axi_awready,
    input wire logic s_axi_wvalid, s_axi_wready, s_axi_arvalid,
    input wire logic s_axi_arready, transceiver_pll_reset,
    input wire logic transceiver_rx_reset, phy_analog_front_reset,
    input wire logic phy_coding_sublayer_reset, phy_elastic_buffer_reset,
    input wire logic phy_equalizer_reset, lane_polarity_invert,
    input wire logic [11:0]          s_axi_awaddr, s_axi_araddr,
    input wire logic [3:0]           s_axi_wstrb,
    input wire sspc_pkg::sspc_word_t s_axi_wdata, s_axi_rdata,
    input wire sspc_pkg::sspc_lpb_t  phy_loopback_select,
    input wire logic [STREAMS-1:0]   pix_fifo_overflow, stream_vsync,
    input wire logic [STREAMS-1:0]   unpack_fifo_overflow,
    input wire logic [STREAMS-1:0]   timing_fifo_overflow
);
    import sspc_pkg::*;
    localparam int OW = 3 * STREAMS;
    logic [OW-1:0] ovf;
    logic          wr_phy, ar_ovf, ar_vs;
    // Full-word PHY write and status read decodes
    assign ovf = {timing_fifo_overflow, unpack_fifo_overflow,
                  pix_fifo_overflow};
    assign wr_phy = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                    s_axi_wready && s_axi_awaddr == 12'h200 &&
                    s_axi_wstrb == 4'hF;
    assign ar_ovf = s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h110;
    assign ar_vs = s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h114;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // PHY controls follow the written word one edge after the update
    a_pll_rx_follow: assert property (wr_phy |-> ##2
        {transceiver_rx_reset, transceiver_pll_reset} ==
        $past(s_axi_wdata[1:0], 2)) else $error("pll or rx reset wrong");
    a_front_follow: assert property (wr_phy |-> ##2
        {phy_equalizer_reset, phy_elastic_buffer_reset,
         phy_coding_sublayer_reset, phy_analog_front_reset} ==
        $past(s_axi_wdata[11:8], 2)) else $error("phy resets wrong");
    a_pol_follow: assert property (wr_phy |=> ##1
        lane_polarity_invert == $past(s_axi_wdata[12], 2))
        else $error("polarity wrong");
    a_lpb_follow: assert property (wr_phy |-> ##2
        phy_loopback_select == $past(s_axi_wdata[15:13], 2))
        else $error("loopback wrong");
    // Values held at the first edge after reset
    a_reset_phy: assert property ($past(rst) |->
        transceiver_pll_reset && transceiver_rx_reset &&
        !lane_polarity_invert && phy_loopback_select == 3'h0)
        else $error("phy reset value wrong");
    // Status reads show past events, live vsync and zero spare bits
    a_flag_seen: assert property (ar_ovf |=>
        (s_axi_rdata[OW-1:0] & $past(ovf, 2)) == $past(ovf, 2))
        else $error("overflow flag lost");
    a_spare_zero: assert property (ar_ovf |=>
        s_axi_rdata[31:OW] == '0) else $error("spare status bit set");
    a_vsync_copy: assert property (ar_vs |=>
        s_axi_rdata == 32'($past(stream_vsync, 2)))
        else $error("vsync readback wrong");
    c_phy_write: cover property (wr_phy);
    c_ovf_read: cover property (ar_ovf ##1 s_axi_rdata != 32'h0);
    c_vs_read: cover property (ar_vs ##1 s_axi_rdata != 32'h0);
endmodule // sspc_regs_checker

// >>> tb/sspc_regs_bench.sv
// Self-checking bench of the status and PHY configuration bank.
// Drives AXI4-Lite and status inputs; binds the port checker.
`timescale 1ns/1ps
module sspc_regs_bench;
    import sspc_pkg::*;
    logic        mclk = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, ev = 12'h0;
    logic [3:0]  s_axi_wstrb = 4'hF, stream_vsync = 4'h0;
    wire  [3:0]  pix_fifo_overflow = ev[3:0];
    wire  [3:0]  unpack_fifo_overflow = ev[7:4];
    wire  [3:0]  timing_fifo_overflow = ev[11:8];
    sspc_word_t  s_axi_wdata = 32'h0, s_axi_rdata, phy_out, d;
    sspc_resp_t  s_axi_bresp, s_axi_rresp, b_q[$];
    sspc_lpb_t   phy_loopback_select;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, transceiver_pll_reset, transceiver_rx_reset;
    logic        phy_analog_front_reset, phy_coding_sublayer_reset, irq;
    logic        phy_elastic_buffer_reset, phy_equalizer_reset;
    logic        lane_polarity_invert;
    logic [33:0] r_q[$];
    int          error_cnt = 0, cmp_count = 0, cyc = 0;
    sspc_regs #(.STREAMS(4)) sspc_regs_inst (.*);
    // PHY outputs gathered in register layout
    assign phy_out = {16'h0, phy_loopback_select, lane_polarity_invert,
        phy_equalizer_reset, phy_elastic_buffer_reset,
        phy_coding_sublayer_reset, phy_analog_front_reset, 6'h00,
        transceiver_rx_reset, transceiver_pll_reset};
    always #12.5 mclk = ~mclk;
    // One comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize();
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Write: both channels offered, each released when taken
    task wr(input logic [11:0] a, input sspc_word_t v,
            input logic [3:0] s, input sspc_resp_t r);
        b_q.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) ||
                   (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge mclk);
        s_axi_bready <= 1'h0;
        @(posedge mclk);
    endtask
    // Read: expected response and data noted first
    task rd(input logic [11:0] a, input sspc_word_t v, input sspc_resp_t r);
        r_q.push_back({r, v});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge mclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        @(posedge mclk);
    endtask
    // Cycle ceiling and response scoreboard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
        if (s_axi_bvalid && s_axi_bready)
            chk(32'(s_axi_bresp), 32'(b_q.pop_front()));
        if (s_axi_rvalid && s_axi_rready) begin
            chk(32'(s_axi_rresp), 32'(r_q[0][33:32]));
            if (r_q[0][33:32] == 2'h0)
                chk(s_axi_rdata, r_q[0][31:0]);
            void'(r_q.pop_front());
        end
    end
    initial begin
        void'($urandom(32423));
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        // Reset state, then random PHY words with spare bits read as zero
        chk(phy_out, 32'h3);
        rd(12'h200, 32'h3, 2'h0);
        repeat (6) begin
            d = $urandom;
            wr(12'h200, d, 4'hF, 2'h0);
            rd(12'h200, d & 32'hFF03, 2'h0);
            chk(phy_out, d & 32'hFF03);
        end
        wr(12'h200, 32'hFFFF_FFFF, 4'h2, 2'h0);
        chk(phy_out, (d & 32'h3) | 32'hFF00);
        wr(12'h200, 32'h0, 4'hF, 2'h0);
        chk(phy_out, 32'h0);
        // Each overflow flag alone, then cleared by its read
        for (int i = 0; i < 12; i++) begin
            ev <= 12'h1 << i;
            @(posedge mclk);
            ev <= 12'h0;
            rd(12'h110, 32'h1 << i, 2'h0);
            rd(12'h110, 32'h0, 2'h0);
        end
        // Events at the clearing read's edge survive it
        ev <= 12'hA81;
        fork
            rd(12'h110, 32'h0, 2'h0);
            begin
                @(posedge mclk);
                ev <= 12'h0;
            end
        join
        rd(12'h110, 32'hA81, 2'h0);
        rd(12'h110, 32'h0, 2'h0);
        // Live vsync under a write attempt, then an unmapped place
        repeat (3) begin
            d = $urandom;
            stream_vsync <= d[3:0];
            repeat (2) @(posedge mclk);
            wr(12'h114, ~d, 4'hF, 2'h0);
            rd(12'h114, 32'(d[3:0]), 2'h0);
        end
        wr(12'h0F0, 32'h1, 4'hF, 2'h2);
        rd(12'h0F0, 32'h0, 2'h2);
        // Interrupt from the earlier events: masked, unmasked, cleared
        chk(32'(irq), 32'h0);
        wr(12'h304, 32'h1, 4'hF, 2'h0);
        chk(32'(irq), 32'h1);
        rd(12'h300, 32'h1, 2'h0);
        wr(12'h300, 32'h1, 4'hF, 2'h0);
        chk(32'(irq), 32'h0);
        rd(12'h304, 32'h1, 2'h0);
        summarize();
    end
endmodule // sspc_regs_bench
// Port checker attached to every instance of the bank
bind sspc_regs sspc_regs_checker #(.STREAMS(STREAMS))
    sspc_regs_checker_inst (.*);
